// ==== include/axis_pkg.sv ====
// What this block does
// - TTL: A leading B counts up
// - Sine: cosine leading sine counts up
// - Two latch inputs, four machine inputs, all active high except the two limits
// - Enable is level, settles within 20 ms
// - Reference switch normally open, within 20 ms
// - Latch edge captures position within 500 ns
// - Limits normally closed, level, within 30 ms
package axis_pkg;
   // Clock rate and period in picoseconds
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // Capture times in their own units
   localparam int unsigned ENABLE_CAPTURE_MS = 20;
   localparam int unsigned REFSW_CAPTURE_MS = 20;
   localparam int unsigned LIMIT_CAPTURE_MS = 30;
   localparam int unsigned LATCH_CAPTURE_NS = 500;
   // Longest times round down to whole cycles
   localparam int unsigned ENABLE_CYCLES = (ENABLE_CAPTURE_MS * 1000000) / (CLK_PERIOD_PS / 1000);
   localparam int unsigned REFSW_CYCLES = (REFSW_CAPTURE_MS * 1000000) / (CLK_PERIOD_PS / 1000);
   localparam int unsigned LIMIT_CYCLES = (LIMIT_CAPTURE_MS * 1000000) / (CLK_PERIOD_PS / 1000);
   localparam int unsigned LATCH_CYCLES = (LATCH_CAPTURE_NS * 1000) / CLK_PERIOD_PS;
   // Widths and reset values
   localparam int POS_W = 32;
   localparam int FILT_CNT_W = 24;
   localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
   localparam int SYNC_STAGES = 2;
   // Feedback source modes
   typedef enum logic {SRC_TTL = 1'b0, SRC_SINE = 1'b1} src_mode_e;
endpackage

// ==== include/level_filter_if.sv ====
`timescale 1ns/10ps
// Carries one synchronised raw level in and its settled value out
interface level_filter_if;
   logic raw;     // Synchronised input level
   logic settled; // Debounced level
   modport owner (output raw, input settled);
   modport filter (input raw, output settled);
endinterface

// ==== design/level_filter.sv ====
`timescale 1ns/10ps
// Accepts a new level only after it holds steady for HOLD_CYCLES
module level_filter
   import axis_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = 4000000
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Levels
   level_filter_if.filter lf
);
   typedef struct packed {
      logic [FILT_CNT_W-1:0] cnt; // Cycles the new level has held
      logic level;                // Accepted level
   } filt_s;

   filt_s state_ff;
   filt_s nxt_state;

   // Restart the count on any bounce, so noise never passes
   always_comb begin
      nxt_state = state_ff;
      if (lf.raw == state_ff.level) begin
         nxt_state.cnt = '0;
      end else if (state_ff.cnt >= FILT_CNT_W'(HOLD_CYCLES - 1)) begin
         nxt_state.level = lf.raw;
         nxt_state.cnt = '0;
      end else begin
         nxt_state.cnt = state_ff.cnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign lf.settled = state_ff.level;
endmodule

// ==== design/axis_feedback_and_input_capture.sv ====
`timescale 1ns/10ps
// Per-axis feedback counter and machine input conditioning
module axis_feedback_and_input_capture
   import axis_pkg::*;
#(
   parameter int unsigned ENABLE_HOLD = ENABLE_CYCLES,
   parameter int unsigned REFSW_HOLD = REFSW_CYCLES,
   parameter int unsigned LIMIT_HOLD = LIMIT_CYCLES
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Feedback tracks and mode
   input wire logic track_a_or_sine_in,
   input wire logic track_b_or_cosine_in,
   input wire logic src_sine_mode_in,
   // Machine inputs, active high at the pins except the limits, which read low when open
   input wire logic axis_enable_in,
   input wire logic reference_switch_in,
   input wire logic positive_limit_input_in,
   input wire logic negative_limit_input_in,
   input wire logic fast_latch_input_1_in,
   input wire logic fast_latch_input_2_in,
   // Latch acknowledges, one per latch
   input wire logic [1:0] latch_ack_in,
   // Results
   output logic [POS_W-1:0] position_out,
   output logic axis_enabled_out,
   output logic reference_closed_out,
   output logic positive_limit_reached_out,
   output logic negative_limit_reached_out,
   output logic [POS_W-1:0] latch_pos_1_out,
   output logic [POS_W-1:0] latch_pos_2_out,
   output logic [1:0] latch_event_out
);
   // Index of every pin in the synchroniser array
   localparam int NPIN = 9;
   localparam int P_A = 0;
   localparam int P_B = 1;
   localparam int P_MODE = 2;
   localparam int P_EN = 3;
   localparam int P_REF = 4;
   localparam int P_PL = 5;
   localparam int P_NL = 6;
   localparam int P_L1 = 7;
   localparam int P_L2 = 8;

   typedef struct packed {
      logic [NPIN-1:0] sync1;      // First stage, read by second stage only
      logic [NPIN-1:0] sync2;      // Second stage
      logic [1:0] tracks_prev;     // Last decoded A/B pair
      logic [1:0] latch_prev;      // Last latch levels for edge detect
      logic [POS_W-1:0] pos;       // Signed position count
      logic [POS_W-1:0] lpos1;     // Captured position, latch 1
      logic [POS_W-1:0] lpos2;     // Captured position, latch 2
      logic [1:0] levent;          // Sticky latch flags
   } axis_s;

   axis_s state_ff;
   axis_s nxt_state;
   logic [NPIN-1:0] pins;
   logic [1:0] trk;
   logic up;
   logic dn;
   logic [1:0] ledge;

   assign pins = {fast_latch_input_2_in, fast_latch_input_1_in, negative_limit_input_in,
                  positive_limit_input_in, reference_switch_in, axis_enable_in,
                  src_sine_mode_in, track_b_or_cosine_in, track_a_or_sine_in};

   // TTL: A is the lead track; sine: cosine leads, so swap roles
   assign trk = (state_ff.sync2[P_MODE] == SRC_SINE) ?
                {state_ff.sync2[P_A], state_ff.sync2[P_B]} :
                {state_ff.sync2[P_B], state_ff.sync2[P_A]};

   // Gray step up: 00-01-11-10 with {lag,lead}; illegal double steps ignored
   always_comb begin
      up = 1'b0;
      dn = 1'b0;
      case ({state_ff.tracks_prev, trk})
         4'b0001, 4'b0111, 4'b1110, 4'b1000: up = 1'b1;
         4'b0010, 4'b1011, 4'b1101, 4'b0100: dn = 1'b1;
         default: begin
            up = 1'b0;
            dn = 1'b0;
         end
      endcase
   end

   // Rising edges of the latch pins, two cycles after the pin
   assign ledge = state_ff.sync2[P_L2:P_L1] & ~state_ff.latch_prev;

   // Next state of the whole axis
   always_comb begin
      nxt_state = state_ff;
      nxt_state.sync1 = pins;
      nxt_state.sync2 = state_ff.sync1;
      nxt_state.tracks_prev = trk;
      nxt_state.latch_prev = state_ff.sync2[P_L2:P_L1];
      if (up) begin
         nxt_state.pos = state_ff.pos + 1'b1;
      end else if (dn) begin
         nxt_state.pos = state_ff.pos - 1'b1;
      end
      // Capture the count before this cycle's step; error is one count at most
      if (ledge[0]) begin
         nxt_state.lpos1 = state_ff.pos;
      end
      if (ledge[1]) begin
         nxt_state.lpos2 = state_ff.pos;
      end
      // Set wins over acknowledge so no edge is lost
      nxt_state.levent = (state_ff.levent & ~latch_ack_in) | ledge;
   end

   // State register; synchronisers and edge history keep running through reset, so the
   // first edges after release compare against real pin levels and never see a false step
   // Limitation: reset must last three edges for that history to be primed
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_ff <= '0;
         state_ff.pos <= POS_RESET;
         state_ff.sync1 <= nxt_state.sync1;
         state_ff.sync2 <= nxt_state.sync2;
         state_ff.tracks_prev <= nxt_state.tracks_prev;
         state_ff.latch_prev <= nxt_state.latch_prev;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Debounced level inputs
   level_filter_if en_if();
   level_filter_if ref_if();
   level_filter_if pl_if();
   level_filter_if nl_if();
   assign en_if.raw = state_ff.sync2[P_EN];
   assign ref_if.raw = state_ff.sync2[P_REF];
   // Limits are normally closed: open contact reads low, so invert to get reached
   assign pl_if.raw = ~state_ff.sync2[P_PL];
   assign nl_if.raw = ~state_ff.sync2[P_NL];

   level_filter #(.HOLD_CYCLES(ENABLE_HOLD)) u_en (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .lf(en_if));
   level_filter #(.HOLD_CYCLES(REFSW_HOLD)) u_ref (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .lf(ref_if));
   level_filter #(.HOLD_CYCLES(LIMIT_HOLD)) u_pl (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .lf(pl_if));
   level_filter #(.HOLD_CYCLES(LIMIT_HOLD)) u_nl (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .lf(nl_if));

   // Outputs; filters reset to 0, so limits read not reached until settled
   assign position_out = state_ff.pos;
   assign axis_enabled_out = en_if.settled;
   assign reference_closed_out = ref_if.settled;
   assign positive_limit_reached_out = pl_if.settled;
   assign negative_limit_reached_out = nl_if.settled;
   assign latch_pos_1_out = state_ff.lpos1;
   assign latch_pos_2_out = state_ff.lpos2;
   assign latch_event_out = state_ff.levent;

   // Count checks: each decoded step moves the count by one, and nothing else moves it
   AST_COUNT_UP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      up |=> position_out == $past(position_out) + 1'b1)
      else $error("count did not step up");
   AST_COUNT_DN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      dn |=> position_out == $past(position_out) - 1'b1)
      else $error("count did not step down");
   AST_HOLD_COUNT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !up && !dn |=> $stable(position_out))
      else $error("count moved without a step");
   AST_NO_BOTH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !(up && dn))
      else $error("up and down together");

   // Latch checks: a pin rise sampled at one edge shows in the flag three edges later
   AST_LATCH1: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $rose(fast_latch_input_1_in) |-> ##3 latch_event_out[0])
      else $error("latch 1 edge not flagged in 3 cycles");
   AST_LATCH2: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $rose(fast_latch_input_2_in) |-> ##3 latch_event_out[1])
      else $error("latch 2 edge not flagged in 3 cycles");
   AST_LATCH_VAL1: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      ledge[0] |=> latch_pos_1_out == $past(position_out))
      else $error("latch 1 value wrong");
   AST_LATCH_VAL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      ledge[1] |=> latch_pos_2_out == $past(position_out))
      else $error("latch 2 value wrong");
   AST_LPOS_HOLD1: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !ledge[0] |=> $stable(latch_pos_1_out))
      else $error("latch 1 value moved without an edge");
   AST_LPOS_HOLD2: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !ledge[1] |=> $stable(latch_pos_2_out))
      else $error("latch 2 value moved without an edge");
   AST_STICKY: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      latch_event_out[0] && !latch_ack_in[0] |=> latch_event_out[0])
      else $error("latch flag dropped without acknowledge");
   AST_STICKY2: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      latch_event_out[1] && !latch_ack_in[1] |=> latch_event_out[1])
      else $error("latch 2 flag dropped without acknowledge");
   AST_ACK_CLEAR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      latch_ack_in[0] && !ledge[0] |=> !latch_event_out[0])
      else $error("latch 1 flag not cleared by acknowledge");

   // Level checks: enable and reference only ever move to the level their filter has been fed; a limit only rises when its contact is open
   AST_EN_STABLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $changed(axis_enabled_out) |-> $past(en_if.raw) == axis_enabled_out)
      else $error("enable changed to unseen level");
   AST_REF_STABLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $changed(reference_closed_out) |-> $past(ref_if.raw) == reference_closed_out)
      else $error("reference changed to unseen level");
   AST_LIMIT_NC: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $rose(positive_limit_reached_out) |-> !$past(state_ff.sync2[P_PL]))
      else $error("limit reached while contact closed");
   AST_NL_NC: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $rose(negative_limit_reached_out) |-> !$past(state_ff.sync2[P_NL]))
      else $error("negative limit reached while contact closed");

   // Main scenarios
   COV_UP: cover property (@(posedge clk_in) up);
   COV_DN: cover property (@(posedge clk_in) dn);
   COV_SINE: cover property (@(posedge clk_in) state_ff.sync2[P_MODE] && dn);
   COV_LATCH: cover property (@(posedge clk_in) ledge[0] ##1 latch_ack_in[0]);
   COV_LIMIT: cover property (@(posedge clk_in) $rose(negative_limit_reached_out));
endmodule

// ==== verification/encoder_model.sv ====
`timescale 1ns/10ps
// Far side: incremental encoder tracks and field limit contacts
module encoder_model (
   // Pacing clock
   input wire logic clk_in,
   // Tracks and contacts
   output logic track_a_out,
   output logic track_b_out,
   output logic pos_contact_out,
   output logic neg_contact_out
);
   logic [1:0] phase = 2'h0; // Quadrature phase, A-leading order 00,10,11,01
   // Gray order: one track moves per step, never both
   assign track_a_out = phase[1] ^ phase[0];
   assign track_b_out = phase[1];
   // Normally closed contacts read high until opened or broken
   initial begin
      pos_contact_out = 1'b1;
      neg_contact_out = 1'b1;
   end
   // One edge forward (A leads) or back (B leads), held 3 cycles
   task step(input bit lead_a);
      phase = lead_a ? phase + 2'h1 : phase - 2'h1;
      repeat (3) @(posedge clk_in);
      #1;
   endtask
   // Low means the contact is open, as a reached limit or a cut wire
   task set_contacts(input bit p, input bit n);
      pos_contact_out = p;
      neg_contact_out = n;
   endtask
endmodule

// ==== verification/axis_feedback_and_input_capture_tb.sv ====
`timescale 1ns/10ps
// Self-checking bench for the feedback counter and machine inputs
module axis_feedback_and_input_capture_tb;
   import axis_pkg::*;
   localparam int unsigned HOLD = 8; // Short debounce keeps the run brief
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic src_sine_mode_in = 1'b0;
   logic axis_enable_in = 1'b0;
   logic reference_switch_in = 1'b0;
   logic [1:0] latch_pin = 2'h0;
   logic [1:0] latch_ack_in = 2'h0;
   logic track_a, track_b, pos_pin, neg_pin;
   logic [POS_W-1:0] position_out, latch_pos_1_out, latch_pos_2_out;
   logic axis_enabled_out, reference_closed_out, pos_reached, neg_reached;
   logic [1:0] latch_event_out;
   logic [3:0] levels; // Enable, reference, positive, negative
   int n_errors = 0;
   int cmp_count = 0;
   int exp_pos = 0;
   assign levels = {axis_enabled_out, reference_closed_out, pos_reached, neg_reached};
   // 200 MHz clock
   always #2.5 clk_in = ~clk_in;
   encoder_model encoder_model_i (.clk_in(clk_in), .track_a_out(track_a),
      .track_b_out(track_b), .pos_contact_out(pos_pin), .neg_contact_out(neg_pin));
   axis_feedback_and_input_capture #(.ENABLE_HOLD(HOLD), .REFSW_HOLD(HOLD),
      .LIMIT_HOLD(HOLD)) axis_feedback_and_input_capture_i (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .track_a_or_sine_in(track_a),
      .track_b_or_cosine_in(track_b), .src_sine_mode_in(src_sine_mode_in),
      .axis_enable_in(axis_enable_in), .reference_switch_in(reference_switch_in),
      .positive_limit_input_in(pos_pin), .negative_limit_input_in(neg_pin),
      .fast_latch_input_1_in(latch_pin[0]), .fast_latch_input_2_in(latch_pin[1]),
      .latch_ack_in(latch_ack_in), .position_out(position_out),
      .axis_enabled_out(axis_enabled_out), .reference_closed_out(reference_closed_out),
      .positive_limit_reached_out(pos_reached), .negative_limit_reached_out(neg_reached),
      .latch_pos_1_out(latch_pos_1_out), .latch_pos_2_out(latch_pos_2_out),
      .latch_event_out(latch_event_out));
   // Wait edges, then step just past the last one
   task cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Four-state compare so an unknown never matches
   task check(input string name, input logic [POS_W-1:0] seen, input logic [POS_W-1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Counts, verdict and stop
   task end_sim;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Expected count after one edge
   function automatic int next_pos(input int p, input bit up);
      return up ? p + 1 : p - 1;
   endfunction
   // Random walk; in sine mode up means cosine (track B) leads
   task run_steps(input int n);
      bit up;
      for (int i = 0; i < n; i++) begin
         up = 1'($urandom % 2);
         encoder_model_i.step(up ^ src_sine_mode_in);
         exp_pos = next_pos(exp_pos, up);
         check("position", position_out, exp_pos);
      end
   endtask
   // Watchdog, well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk_in);
      n_errors++;
      end_sim();
   end
   // Main sequence
   initial begin
      void'($urandom(32'h7b803d20));
      cyc(12);
      sys_rst_in = 1'b0;
      check("reset levels", levels, 4'h0);
      run_steps(40);
      // Pulses shorter than the hold must be ignored
      axis_enable_in = 1'b1;
      reference_switch_in = 1'b1;
      encoder_model_i.set_contacts(1'b0, 1'b0);
      cyc(4);
      axis_enable_in = 1'b0;
      reference_switch_in = 1'b0;
      encoder_model_i.set_contacts(1'b1, 1'b1);
      cyc(HOLD + 4);
      check("glitch levels", levels, 4'h0);
      // Held levels pass after exactly 2+HOLD edges
      axis_enable_in = 1'b1;
      reference_switch_in = 1'b1;
      encoder_model_i.set_contacts(1'b0, 1'b1);
      cyc(HOLD + 1);
      check("early levels", levels, 4'h0);
      cyc(1);
      check("held levels", levels, 4'he);
      // Enable and reference fall; the positive contact closes and only the negative one opens, as a cut wire
      axis_enable_in = 1'b0;
      reference_switch_in = 1'b0;
      encoder_model_i.set_contacts(1'b1, 1'b0);
      cyc(HOLD + 2);
      check("cut wire levels", levels, 4'h1);
      // Each latch: capture, stay sticky, clear on acknowledge
      for (int k = 0; k < 2; k++) begin
         run_steps(3);
         latch_pin[k] = 1'b1;
         cyc(3);
         check("latch flag", latch_event_out, 2'h1 << k);
         check("latch pos", k ? latch_pos_2_out : latch_pos_1_out, exp_pos);
         latch_pin[k] = 1'b0;
         run_steps(2);
         check("sticky flag", latch_event_out, 2'h1 << k);
         latch_ack_in[k] = 1'b1;
         cyc(1);
         latch_ack_in[k] = 1'b0;
         cyc(1);
         check("acked flag", latch_event_out, 2'h0);
      end
      // Acknowledge held across the edge that sets the flag: the set must win
      latch_pin[0] = 1'b1;
      cyc(2);
      latch_ack_in[0] = 1'b1;
      cyc(1);
      check("set beats ack", latch_event_out, 2'h1);
      latch_pin[0] = 1'b0;
      cyc(1);
      latch_ack_in[0] = 1'b0;
      check("acked again", latch_event_out, 2'h0);
      // Sine/cosine source after a second reset
      sys_rst_in = 1'b1;
      src_sine_mode_in = 1'b1;
      cyc(2);
      sys_rst_in = 1'b0;
      exp_pos = 0;
      check("reset position", position_out, 32'h0);
      run_steps(40);
      end_sim();
   end
endmodule
